//--- bench/adc_trigger_sequencer_test.sv
// self-checking bench for the conversion-slot sequencer
// assumes the converter model beside it and a zero-wait apb slave
`timescale 1ns/1ps
module adc_trigger_sequencer_test
   import adcts_pkg::*;
;
   logic             core_clk;
   logic             rst_n;
   logic [7:0]       paddr;
   logic             psel;
   logic             penable;
   logic             pwrite;
   logic [31:0]      pwdata;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   logic [NPWM-1:0]  req_a;
   logic [NPWM-1:0]  req_b;
   logic             grp_b;
   logic [2:0]       pin_in;
   logic             sample;
   logic             convert;
   logic             ready;
   logic [RES_W-1:0] data;
   logic             irq;
   logic [3:0]       latency;
   logic [3:0]       last_pin;
   int               last_win;
   int               fails;
   int               cmp_count;
   int               conv_cnt;
   int               irq_cnt;
   logic [31:0]      rd;
   logic             er;

   adcts_sequencer dut_u (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pwm_conversion_request_a(req_a), .pwm_conversion_request_b(req_b),
      .adc_group_b(grp_b), .adc_input(pin_in), .adc_sample(sample), .adc_convert(convert),
      .adc_ready(ready), .adc_data(data), .conversion_interrupt_one(irq));
   adcts_adc_model model_u (.core_clk(core_clk), .rst_n(rst_n), .adc_group_b(grp_b),
      .adc_input(pin_in), .adc_sample(sample), .adc_convert(convert), .latency(latency),
      .adc_ready(ready), .adc_data(data), .last_pin(last_pin), .last_win(last_win));

   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
   begin
      if (ready === 1'b1)
         conv_cnt++;
      if (irq === 1'b1)
         irq_cnt++;
   end

   // ==========================================================
   // helpers
   task automatic finish_test();
      $display("fails=%0d cmp_count=%0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic timeout(input string m);
      fails++;
      $display("mismatch at %0t: timeout %s", $time, m);
      finish_test();
   endtask

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      psel    <= 1'b1;
      penable <= 1'b0;
      @(posedge core_clk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++)
      begin
         @(posedge core_clk);
         if (pready === 1'b1)
            break;
      end
      if (n == 16)
         timeout("apb");
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
      apb(a, 1'b0, 32'h0000_0000);
      check(rd & msk, exp, "read");
   endtask

   task automatic wait_conv(input int target);
      for (int n = 0; n < 400 && conv_cnt < target; n++)
         @(posedge core_clk);
      if (conv_cnt < target)
         timeout("conversion");
      repeat (3) @(posedge core_clk);
   endtask

   task automatic pulse(input logic b, input int i);
      @(posedge core_clk);
      if (b) req_b[i] <= 1'b1; else req_a[i] <= 1'b1;
      repeat (4) @(posedge core_clk);
      req_a <= 4'h0;
      req_b <= 4'h0;
   endtask

   function automatic logic [31:0] exp_res(input logic [3:0] c);
      return {20'h00000, c, ~c, c};
   endfunction

   // ==========================================================
   // scenarios
   task automatic t_reset();
      rd_chk(OFF_ISEL, 32'h0000_0010, 32'hFFFF_FFFF);
      rd_chk(OFF_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
      apb(8'h3C, 1'b0, 32'h0000_0000);
      check({31'h0, er}, 32'h1, "unmapped err");
   endtask

   task automatic t_mode0();
      int c;
      apb(8'h40, 1'b1, {18'h0, 6'h03, TRIG_A0, PIN_CODE_B5});
      apb(8'h44, 1'b1, {18'h0, 6'h00, TRIG_B0 + 4'h3, PIN_CODE_A3});
      apb(OFF_ISEL, 1'b1, 32'h0000_0000);
      apb(OFF_MASK, 1'b1, 32'h0000_0001);
      apb(OFF_CTRL, 1'b1, 32'h0000_0010);
      latency <= 4'h5;
      c = conv_cnt;
      pulse(1'b0, 1);
      repeat (20) @(posedge core_clk);
      check(conv_cnt, c, "unselected trigger");
      pulse(1'b0, 0);
      wait_conv(c + 1);
      check({28'h0, last_pin}, 32'hD, "pin slot0");
      check(last_win, 4, "window slot0");
      check({31'h0, irq}, 32'h1, "irq slot0");
      rd_chk(8'h80, exp_res(PIN_CODE_B5), 32'hFFFF_FFFF);
      latency <= 4'h0;
      pulse(1'b1, 3);
      wait_conv(c + 2);
      check({28'h0, last_pin}, 32'h3, "pin slot1");
      check(last_win, 1, "window slot1");
      rd_chk(8'h84, exp_res(PIN_CODE_A3), 32'hFFFF_FFFF);
      rd_chk(OFF_STAT, 32'h1, 32'h1);
      apb(OFF_MASK, 1'b1, 32'h0000_0000);
      @(posedge core_clk);
      check({31'h0, irq}, 32'h0, "masked irq");
      apb(OFF_MASK, 1'b1, 32'h0000_0001);
      apb(OFF_STAT, 1'b1, 32'h0000_0003);
      @(posedge core_clk);
      check({31'h0, irq}, 32'h0, "cleared irq");
      pulse(1'b1, 3);
      wait_conv(c + 3);
      check({31'h0, irq}, 32'h0, "non-selected slot irq");
   endtask

   task automatic t_none();
      apb(OFF_ISEL, 1'b1, {27'h0, ISEL_NONE});
      pulse(1'b0, 0);
      wait_conv(conv_cnt + 1);
      check({31'h0, irq}, 32'h0, "irq with no slot");
      rd_chk(OFF_STAT, 32'h0, 32'h1);
      apb(OFF_ISEL, 1'b1, 32'h0000_0000);
   endtask

   task automatic t_auto();
      int k;
      apb(OFF_CTRL, 1'b1, 32'h0000_0012);
      k = irq_cnt;
      pulse(1'b0, 0);
      wait_conv(conv_cnt + 1);
      check(irq_cnt - k, 1, "auto irq length");
      rd_chk(OFF_STAT, 32'h0, 32'h1);
   endtask

   task automatic t_force();
      int c;
      c = conv_cnt;
      apb(8'h48, 1'b1, {18'h0, 6'h3F, TRIG_SW, 4'h5});
      repeat (3) apb(OFF_FORCE, 1'b1, 32'h0000_0004);
      rd_chk(OFF_STAT, 32'h2, 32'h2);
      wait_conv(c + 1);
      check({28'h0, last_pin}, 32'h5, "pin forced slot");
      check(last_win, 64, "window forced slot");
      wait_conv(c + 2);
      apb(OFF_STAT, 1'b1, 32'h0000_0003);
   endtask

   task automatic t_cont();
      int n;
      apb(OFF_CTRL, 1'b1, 32'h0000_0011);
      wait_conv(conv_cnt + 3);
      apb(OFF_CTRL, 1'b1, 32'h0000_0000);
      for (n = 0; n < 20; n++)
      begin
         apb(OFF_STAT, 1'b0, 32'h0000_0000);
         if (rd[ST_BUSY_BIT] === 1'b0)
            break;
      end
      check({31'h0, rd[ST_BUSY_BIT]}, 32'h0, "engine idle");
      apb(OFF_STAT, 1'b1, 32'h0000_0003);
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      fails = 0;
      cmp_count = 0;
      conv_cnt = 0;
      irq_cnt = 0;
      rst_n = 1'b0;
      paddr = 8'h00;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h0000_0000;
      req_a = 4'h0;
      req_b = 4'h0;
      latency = 4'h2;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_mode0();
      t_none();
      t_auto();
      t_force();
      t_cont();
      finish_test();
   end
endmodule // adc_trigger_sequencer_test

//--- bench/adcts_adc_model.sv
// behavioural analog converter: measures the sample window, answers a convert
// assumes the sequencer drives its converter outputs on core_clk
`timescale 1ns/1ps
module adcts_adc_model
   import adcts_pkg::*;
(
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             adc_group_b,
   input  wire logic [2:0]       adc_input,
   input  wire logic             adc_sample,
   input  wire logic             adc_convert,
   input  wire logic [3:0]       latency,
   output logic                  adc_ready,
   output logic      [RES_W-1:0] adc_data,
   output logic      [3:0]       last_pin,
   output int                    last_win
);
   int cnt;
   int win;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         adc_ready <= 1'b0;
         adc_data  <= 12'h000;
         last_pin  <= 4'h0;
         last_win  <= 0;
         cnt       <= 0;
         win       <= 0;
      end
      else
      begin
         adc_ready <= 1'b0;
         // released bus: data toggles outside the ready pulse
         adc_data  <= ~adc_data;
         if (adc_sample)
            win <= win + 1;
         else if (win != 0)
         begin
            last_win <= win;
            win      <= 0;
         end
         if (adc_convert)
         begin
            cnt      <= int'(latency) + 1;
            last_pin <= {adc_group_b, adc_input};
         end
         else if (cnt == 1)
         begin
            cnt       <= 0;
            adc_ready <= 1'b1;
            adc_data  <= {last_pin, ~last_pin, last_pin};
         end
         else if (cnt > 1)
            cnt <= cnt - 1;
      end
   end
endmodule // adcts_adc_model

//--- logic/adcts_conv.sv
// conversion engine: acquisition window, then converter handshake
// assumes the analog macro answers adc_ready on this clock
`timescale 1ns/1ps
module adcts_conv
   import adcts_pkg::*;
(
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             start,
   input  wire logic [3:0]       pin,
   input  wire logic [5:0]       acq,
   input  wire logic             adc_ready,
   input  wire logic [RES_W-1:0] adc_data,
   output logic                  adc_group_b,
   output logic      [2:0]       adc_input,
   output logic                  adc_sample,
   output logic                  adc_convert,
   output logic                  done,
   output logic      [RES_W-1:0] result,
   output logic                  busy
);

   typedef struct packed {
      adcts_conv_e      state;
      logic [5:0]       cnt;
      logic [5:0]       acq_len;
      logic [3:0]       pin;
      logic             convert;
      logic             done;
      logic [RES_W-1:0] result;
   } adcts_conv_s;

   adcts_conv_s st;
   adcts_conv_s next_st;

   always_comb
   begin
      next_st = st;
      next_st.convert = 1'b0;
      next_st.done = 1'b0;
      unique case (st.state)
         CV_IDLE:
            if (start)
            begin
               next_st.state = CV_ACQ;
               next_st.cnt = acq;
               next_st.acq_len = acq;
               next_st.pin = pin;
            end
         // R3 window of acq+1 cycles
         CV_ACQ:
            if (st.cnt == 6'h0)
            begin
               next_st.state = CV_CONV;
               next_st.convert = 1'b1;
            end
            else
               next_st.cnt = st.cnt - 6'h1;
         // R11 twelve-bit result
         CV_CONV:
            if (adc_ready)
            begin
               next_st.state = CV_IDLE;
               next_st.done = 1'b1;
               next_st.result = adc_data;
            end
         default:
            next_st.state = CV_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end

   // R10 code bit 3 picks group b
   assign adc_group_b = st.pin[3];
   assign adc_input   = st.pin[2:0];
   assign adc_sample  = (st.state == CV_ACQ);
   assign adc_convert = st.convert;
   assign done        = st.done;
   assign result      = st.result;
   assign busy        = (st.state != CV_IDLE);

   // ==========================================================
   // checks
   logic [6:0] sample_len;
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         sample_len <= 7'h0;
      else
         sample_len <= adc_sample ? sample_len + 7'h1 : 7'h0;
   end

   // R3 window length
   a_acq_length: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
      $fell(adc_sample) |-> sample_len == {1'b0, st.acq_len} + 7'h1)
      else $error("acquisition window length wrong");

endmodule // adcts_conv

//--- logic/adcts_pkg.sv
// constants for the conversion-slot sequencer: register map, fields, modes
// assumes an APB slave with an 8-bit byte address and 32-bit data
package adcts_pkg;

   // ==========================================================
   // sizes
   localparam int NSLOT = 16;
   localparam int RES_W = 12;
   localparam int NPWM  = 4;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFF_CTRL  = 8'h00;
   localparam logic [7:0] OFF_ISEL  = 8'h04;
   localparam logic [7:0] OFF_STAT  = 8'h08;
   localparam logic [7:0] OFF_MASK  = 8'h0C;
   localparam logic [7:0] OFF_FORCE = 8'h10;
   localparam logic [1:0] PAGE_CFG  = 2'h1;
   localparam logic [1:0] PAGE_RES  = 2'h2;

   // ==========================================================
   // fields and reset values
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_RUN_BIT  = 4;
   localparam int ST_INT        = 0;
   localparam int ST_OVF        = 1;
   localparam int ST_BUSY_BIT   = 8;
   localparam int ST_CUR_LSB    = 12;
   localparam int CFG_PIN_LSB   = 0;
   localparam int CFG_TRIG_LSB  = 4;
   localparam int CFG_ACQ_LSB   = 8;
   localparam int CFG_W         = 14;
   localparam logic [4:0] ISEL_NONE = 5'h10;

   // ==========================================================
   // modes, trigger codes, pin codes
   localparam logic [1:0] MODE_START_STOP = 2'h0;
   localparam logic [1:0] MODE_CONT       = 2'h1;
   localparam logic [1:0] MODE_AUTO       = 2'h2;
   localparam logic [3:0] TRIG_SW         = 4'h0;
   localparam logic [3:0] TRIG_A0         = 4'h1;
   localparam logic [3:0] TRIG_B0         = 4'h5;
   localparam logic [3:0] PIN_CODE_B5     = 4'hD;
   localparam logic [3:0] PIN_CODE_A3     = 4'h3;

   typedef enum logic [1:0] {CV_IDLE, CV_ACQ, CV_CONV} adcts_conv_e;

endpackage

//--- logic/adcts_sequencer.sv
// conversion-slot sequencer top: apb registers, slot queue, interrupt flag
// assumes apb master on core_clk, analog macro and pwm requests outside
//
// Contract
// R1 - each slot converts the pin named by its own pin code
// R2 - each slot starts only on its own selected trigger source
// R3 - each slot samples for its own acquisition window before converting
// R4 - interrupt slot select names the interrupting slot; 0x10 means none
// R5 - mode 0: triggered starts, interrupt on each selected slot completion
// R6 - mode 0: software clears the flag; no re-raise while it stays set
// R7 - mode 1: continuous conversion without waiting for triggers
// R8 - mode 2: triggered starts; interrupt flag clears itself automatically
// R9 - trigger sources include pwm request a and b outputs
// R10 - pin code 13 is group b input 5, code 3 group a input 3
// R11 - results carry twelve bits across the reference range
// R12 - sixteen slots 0 to 15; select value 16 matches none
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module adcts_sequencer
   import adcts_pkg::*;
(
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic [7:0]       paddr,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic [NPWM-1:0]  pwm_conversion_request_a,
   input  wire logic [NPWM-1:0]  pwm_conversion_request_b,
   output logic                  adc_group_b,
   output logic      [2:0]       adc_input,
   output logic                  adc_sample,
   output logic                  adc_convert,
   input  wire logic             adc_ready,
   input  wire logic [RES_W-1:0] adc_data,
   output logic                  conversion_interrupt_one
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [1:0]                        mode;
      logic                              run;
      logic [4:0]                        isel;
      logic [1:0]                        stat;
      logic [1:0]                        mask;
      logic [NSLOT-1:0]                  sw_force;
      logic [NSLOT-1:0]                  pend;
      logic [3:0]                        cur;
      logic [3:0]                        rr;
      logic [NSLOT-1:0][CFG_W-1:0]       cfg;
      logic [NSLOT-1:0][RES_W-1:0]       res;
      logic [31:0]                       prdata;
   } adcts_regs_s;

   adcts_regs_s st;
   adcts_regs_s next_st;

   logic                   start;
   logic [3:0]             sslot;
   logic [3:0]             start_pin;
   logic [5:0]             start_acq;
   logic [NSLOT-1:0]       slot_hit;
   logic [NSLOT-1:0][3:0]  trig_sel;
   logic                   conv_done;
   logic                   conv_busy;
   logic [RES_W-1:0]       conv_result;
   logic                   wr;
   logic                   rd_setup;

   // ==========================================================
   // helpers
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a[1:0] == 2'h0) &&
                (a == OFF_CTRL ||
                 a == OFF_ISEL ||
                 a == OFF_STAT ||
                 a == OFF_MASK ||
                 a == OFF_FORCE ||
                 a[7:6] == PAGE_CFG ||
                 a[7:6] == PAGE_RES);
   endfunction

   // scans down so the lowest set bit wins
   function automatic logic [3:0] lowest(input logic [NSLOT-1:0] v);
      lowest = 4'h0;
      for (int i = NSLOT - 1; i >= 0; i--)
         if (v[i])
            lowest = 4'(i);
   endfunction

   // ==========================================================
   // submodules
   // trigger code field per slot
   always_comb
   begin
      for (int i = 0; i < NSLOT; i++)
         trig_sel[i] = st.cfg[i][CFG_TRIG_LSB +: 4];
   end

   adcts_trig u_trig (
      .core_clk                 (core_clk),
      .rst_n                    (rst_n),
      .pwm_conversion_request_a (pwm_conversion_request_a),
      .pwm_conversion_request_b (pwm_conversion_request_b),
      .slot_trig_sel            (trig_sel),
      .sw_force                 (st.sw_force),
      .slot_hit                 (slot_hit)
   );

   adcts_conv u_conv (
      .core_clk    (core_clk),
      .rst_n       (rst_n),
      .start       (start),
      .pin         (start_pin),
      .acq         (start_acq),
      .adc_ready   (adc_ready),
      .adc_data    (adc_data),
      .adc_group_b (adc_group_b),
      .adc_input   (adc_input),
      .adc_sample  (adc_sample),
      .adc_convert (adc_convert),
      .done        (conv_done),
      .result      (conv_result),
      .busy        (conv_busy)
   );

   // ==========================================================
   // next state
   always_comb
   begin
      next_st = st;
      next_st.sw_force = '0;
      wr = psel && penable && pwrite;
      rd_setup = psel && !penable && !pwrite;
      // R8 flag lives one cycle in mode 2
      if (st.mode == MODE_AUTO)
         next_st.stat[ST_INT] = 1'b0;

      // register writes
      if (wr && addr_ok(paddr))
      begin
         if (paddr == OFF_CTRL)
         begin
            next_st.mode = pwdata[CTRL_MODE_LSB +: 2];
            next_st.run = pwdata[CTRL_RUN_BIT];
         end
         // R4 interrupt slot select
         if (paddr == OFF_ISEL)
            next_st.isel = pwdata[4:0];
         // R6 software clears by writing one
         if (paddr == OFF_STAT)
            next_st.stat = next_st.stat & ~pwdata[1:0];
         if (paddr == OFF_MASK)
            next_st.mask = pwdata[1:0];
         if (paddr == OFF_FORCE)
            next_st.sw_force = pwdata[NSLOT-1:0];
         if (paddr[7:6] == PAGE_CFG)
            next_st.cfg[paddr[5:2]] = pwdata[CFG_W-1:0];
      end

      // read data captured in the setup cycle
      if (rd_setup)
      begin
         next_st.prdata = 32'h0;
         if (paddr == OFF_CTRL)
            next_st.prdata = 32'({st.run, 2'h0, st.mode});
         if (paddr == OFF_ISEL)
            next_st.prdata = 32'(st.isel);
         if (paddr == OFF_STAT)
         begin
            next_st.prdata[1:0] = st.stat;
            next_st.prdata[ST_BUSY_BIT] = conv_busy;
            next_st.prdata[ST_CUR_LSB +: 4] = st.cur;
         end
         if (paddr == OFF_MASK)
            next_st.prdata = 32'(st.mask);
         if (paddr[7:6] == PAGE_CFG)
            next_st.prdata = 32'(st.cfg[paddr[5:2]]);
         if (paddr[7:6] == PAGE_RES)
            next_st.prdata = 32'(st.res[paddr[5:2]]);
      end

      // start the next slot when the engine is free
      start = 1'b0;
      sslot = lowest(st.pend);
      if (st.run && !conv_busy)
      begin
         // R7 round robin, no triggers
         if (st.mode == MODE_CONT)
         begin
            start = 1'b1;
            sslot = st.rr;
            next_st.rr = st.rr + 4'h1;
         end
         // R5 lowest pending slot first
         else if (|st.pend)
         begin
            start = 1'b1;
            next_st.pend[sslot] = 1'b0;
         end
      end
      if (start)
         next_st.cur = sslot;
      // R1 pin and window of the started slot
      start_pin = st.cfg[sslot][CFG_PIN_LSB +: 4];
      start_acq = st.cfg[sslot][CFG_ACQ_LSB +: 6];

      // R2 each slot queued by its own trigger
      for (int i = 0; i < NSLOT; i++)
      begin
         if (slot_hit[i] && st.run && st.mode != MODE_CONT)
         begin
            if (next_st.pend[i])
               next_st.stat[ST_OVF] = 1'b1;
            next_st.pend[i] = 1'b1;
         end
      end
      if (!st.run)
         next_st.pend = '0;

      // completion: store result, raise flag (set wins over clear)
      if (conv_done)
      begin
         // R11 twelve-bit result stored per slot
         next_st.res[st.cur] = conv_result;
         // R12 select 16 matches no slot
         if (!st.isel[4] && st.isel[3:0] == st.cur)
            next_st.stat[ST_INT] = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st <= '0;
         st.isel <= ISEL_NONE;
      end
      else
         st <= next_st;
   end

   // ==========================================================
   // outputs
   assign prdata  = st.prdata;
   assign pready  = 1'b1;
   // unmapped or unaligned access
   assign pslverr = psel && penable && !addr_ok(paddr);
   // R5 irq from unmasked flags
   assign conversion_interrupt_one = |(st.stat & st.mask);

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // R1 pin follows slot
   a_pin_follows_slot: assert property ( // R1
      start |=> {adc_group_b, adc_input} == $past(start_pin))
      else $error("converted pin differs from slot pin code");

   // R2 trigger gets queued
   a_trig_queues: assert property ( // R2
      (slot_hit[3] && st.run && st.mode == MODE_START_STOP)
      |=> (st.pend[3] || st.cur == 4'h3))
      else $error("slot trigger not queued");

   // R3 convert follows window
   a_acq_to_conv: assert property ( // R3
      $rose(adc_sample) |-> ##[1:64] adc_convert)
      else $error("no conversion after acquisition");

   // R4 no slot selected
   a_int_none: assert property ( // R4
      (conv_done && st.isel == ISEL_NONE && !st.stat[ST_INT]) |=> !st.stat[ST_INT])
      else $error("flag raised with no interrupt slot");

   // R5 selected slot raises flag
   a_int_raise: assert property ( // R5
      (conv_done && st.mode == MODE_START_STOP && st.isel == {1'b0, st.cur})
      |=> st.stat[ST_INT])
      else $error("selected slot completion did not raise flag");

   // R7 continuous start
   a_cont_runs: assert property ( // R7
      (st.run && st.mode == MODE_CONT && !conv_busy) |-> start ##1 conv_busy)
      else $error("continuous mode did not start");

   // R8 flag clears itself
   a_auto_clear: assert property ( // R8
      (st.mode == MODE_AUTO && st.stat[ST_INT] && !conv_done)
      |=> !st.stat[ST_INT])
      else $error("mode 2 flag not cleared automatically");

   // R10 code 13 group b
   a_pin_map: assert property ( // R10
      (start && start_pin == PIN_CODE_B5) |=> (adc_group_b && adc_input == 3'h5))
      else $error("pin code 13 not group b input 5");

   // R11 result stored
   a_result_kept: assert property ( // R11
      conv_done |=> st.res[$past(st.cur)] == $past(conv_result))
      else $error("result not stored for slot");

   // R5 irq output level
   a_int_output: assert property ( // R5
      (st.stat[ST_INT] && st.mask[ST_INT]) |-> conversion_interrupt_one)
      else $error("interrupt output not raised");

   // R6 flag holds until cleared
   a_flag_sticky: assert property ( // R6
      (st.mode == MODE_START_STOP && st.stat[ST_INT]
       && !(wr && paddr == OFF_STAT && pwdata[ST_INT])) |=> st.stat[ST_INT])
      else $error("mode 0 flag dropped");

   // R7 slots in turn
   a_cont_order: assert property ( // R7
      (start && st.mode == MODE_CONT) |=> st.cur == $past(st.rr))
      else $error("continuous slot out of turn");

   // R10 code 3 group a
   a_pin_a3: assert property ( // R10
      (start && start_pin == PIN_CODE_A3) |=> (!adc_group_b && adc_input == 3'h3))
      else $error("pin code 3 not group a input 3");

   // R2 no queue without trigger
   a_no_stray_queue: assert property ( // R2
      (!slot_hit[5] && !st.pend[5]) |=> !st.pend[5])
      else $error("slot queued without its trigger");

   // ==========================================================
   // coverage
   c_mode0_int: cover property (st.mode == MODE_START_STOP && $rose(st.stat[ST_INT]));
   c_mode2_int: cover property (st.mode == MODE_AUTO && $rose(st.stat[ST_INT]));
   c_cont_wrap: cover property (st.mode == MODE_CONT && start && st.rr == 4'hF);
   c_overrun:   cover property ($rose(st.stat[ST_OVF]));
   c_force_start: cover property (st.sw_force[2] && slot_hit[2]);

endmodule // adcts_sequencer

//--- logic/adcts_trig.sv
// trigger front end: synchronises pwm requests, picks each slot's source
// assumes pwm requests are asynchronous levels, software force is same-clock
`timescale 1ns/1ps
module adcts_trig
   import adcts_pkg::*;
(
   input  wire logic                        core_clk,
   input  wire logic                        rst_n,
   input  wire logic [NPWM-1:0]             pwm_conversion_request_a,
   input  wire logic [NPWM-1:0]             pwm_conversion_request_b,
   input  wire logic [NSLOT-1:0][3:0]       slot_trig_sel,
   input  wire logic [NSLOT-1:0]            sw_force,
   output logic      [NSLOT-1:0]            slot_hit
);

   typedef struct packed {
      logic [2*NPWM-1:0] s1;
      logic [2*NPWM-1:0] s2;
      logic [2*NPWM-1:0] s3;
   } adcts_trig_s;

   adcts_trig_s st;
   adcts_trig_s next_st;
   logic [2*NPWM-1:0] rise;

   // R9 pwm a and b sources
   // source 0 is software, 1..4 request a, 5..8 request b
   function automatic logic pick(input logic [3:0] code, input logic [2*NPWM-1:0] ev, input logic sw);
      pick = 1'b0;
      if (code == TRIG_SW)
         pick = sw;
      else if (code < TRIG_A0 + 4'(2*NPWM))
         pick = ev[3'(code - TRIG_A0)];
   endfunction

   always_comb
   begin
      next_st = st;
      next_st.s1 = {pwm_conversion_request_b, pwm_conversion_request_a};
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      rise = st.s2 & ~st.s3;
      // R2 own source per slot
      for (int i = 0; i < NSLOT; i++)
         slot_hit[i] = pick(slot_trig_sel[i], rise, sw_force[i]);
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
   end

   // ==========================================================
   // checks
   // R9 b0 edge taken
   a_pwm_source: assert property (@(posedge core_clk) disable iff (!rst_n) // R9
      (slot_trig_sel[0] == TRIG_B0 && rise[NPWM]) |-> slot_hit[0])
      else $error("request b0 edge not taken");

endmodule // adcts_trig
